/* rtl/cfg_parser_consts.svh */
// Purpose: Constants for the serial configuration command parser
// Assumes: ASCII command stream, 12-bit converter path
// Notes:   Definitions only
`ifndef CFG_PARSER_CONSTS_SVH
`define CFG_PARSER_CONSTS_SVH

`define CHR_STAR     8'h2a
`define CHR_HASH     8'h23
`define CHR_QUERY    8'h3f
`define CHR_EQ       8'h3d
`define CHR_CR       8'h0d
`define CHR_MINUS    8'h2d
`define CHR_ZERO     8'h30
`define CHR_NINE     8'h39
`define CHR_ONE      8'h31
`define CHR_A        8'h41
`define CHR_C        8'h43
`define CHR_D        8'h44
`define CHR_E        8'h45
`define CHR_I        8'h49
`define CHR_N        8'h4e
`define CHR_P        8'h50
`define CHR_S        8'h53
`define CHR_W        8'h57
`define CHR_X        8'h58
`define CHR_Y        8'h59
`define CHR_Z        8'h5a
`define NAME_NONE    8'h00

`define W_PCT_MAX    10'd99
`define W_FULL_PCT   7'd100
`define W_RESET      7'd0
`define TRIM_LIMIT   10'd120
`define TRIM_RESET   8'h00
`define NUM_SAT      14'd999
`define NULL_ADDR    7'd0
`define ADDR_MAX     10'd99
`define MID_CODE     12'h800
`define REP_DEPTH    12

`define TRIM_STEP_DEN 24'sd20000
`define FS_CODES      24'sd4096
`define MID_CODE_S    24'sd2048
`define DAC_MAX       24'sd4095

`endif

/* rtl/cfg_parser_pkg.sv */
// Purpose: Types shared by the command parser and the output scaler
// Assumes: Constants come from cfg_parser_consts.svh
// Notes:   Types only
package cfg_parser_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_NAME  = 3'b010,
    ST_VALUE = 3'b011,
    ST_SKIP  = 3'b100,
    ST_EXEC  = 3'b101,
    ST_REPLY = 3'b110
  } parse_state_t;
  typedef logic [7:0]        char_t;
  typedef logic signed [7:0] trim_t;
  typedef logic [9:0]        direct_t;
endpackage

/* rtl/output_scaler.sv */
// Purpose: Trim, null and window scaling of the pressure code onto the converter
// Assumes: Offset-binary pressure code for differential units
// Notes:   One register stage; division is combinational
`timescale 1ns/1ps
`include "cfg_parser_consts.svh"
module output_scaler (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      ce_i,
  input  wire logic [11:0]               press_i,
  input  wire logic                      diff_i,
  input  wire logic [6:0]                w_pct_i,
  input  wire logic                      setpt_mode_i,
  input  wire logic [11:0]               setpoint_i,
  input  wire cfg_parser_pkg::trim_t     x_trim_i,
  input  wire cfg_parser_pkg::trim_t     y_trim_i,
  input  wire cfg_parser_pkg::trim_t     z_trim_i,
  input  wire logic signed [12:0]        null_adj_i,
  output logic [11:0]                    dac_code_o
);
  import cfg_parser_pkg::*;

  wire logic signed [23:0] p_s    = $signed({12'h000, press_i});
  wire logic               neg    = diff_i && (press_i < `MID_CODE);
  wire logic signed [23:0] dev    = diff_i ? p_s - `MID_CODE_S : p_s;
  // Negative side of a differential unit uses its own slope
  wire trim_t              slope  = neg ? y_trim_i : x_trim_i; // RULE11
  wire logic signed [23:0] sl_s   = {{16{slope[7]}}, slope};
  wire logic signed [23:0] z_s    = {{16{z_trim_i[7]}}, z_trim_i};
  wire logic signed [23:0] corr   = (dev * sl_s) / `TRIM_STEP_DEN; // RULE10
  wire logic signed [23:0] offs   = (z_s * `FS_CODES) / `TRIM_STEP_DEN; // RULE12
  wire logic signed [23:0] nul_s  = {{11{null_adj_i[12]}}, null_adj_i};
  wire logic signed [23:0] value  = p_s + corr + offs + nul_s; // RULE12
  // Zero width means the full window
  wire logic [6:0]         span   = (w_pct_i == `W_RESET) ? `W_FULL_PCT : w_pct_i; // RULE14
  wire logic signed [23:0] span_s = $signed({17'h00000, span});
  wire logic signed [23:0] low    = setpt_mode_i ? $signed({12'h000, setpoint_i}) : 24'sh000000; // RULE9
  wire logic signed [23:0] scaled = ((value - low) * 24'sd100) / span_s; // RULE9 RULE13
  wire logic [11:0]        code   = (scaled < 24'sd0) ? 12'h000 :
                                    (scaled > `DAC_MAX) ? 12'hfff : scaled[11:0];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dac_code_o <= 12'h000;
    end else if (ce_i) begin
      dac_code_o <= code; // RULE13
    end
  end

  dac_range_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
    (ce_i && scaled > `DAC_MAX) |=> dac_code_o == 12'hfff)
    else $error("converter code not clamped at top");
endmodule

/* rtl/serial_config_command_parser.sv */
// Purpose: Addressed ASCII command interpreter holding transducer configuration
// Assumes: Received and sent bytes are synchronous strobes from a UART
// Notes:   Nonvolatile copy is held in flops; POWER_UP_I restores it
// Function
// (RULE1) Carriage return ends every command from the host.
// (RULE2) Host starts each command with asterisk and two-digit address, 00 if unassigned.
// (RULE3) Replies start with ?01 when unassigned, else hash and own address.
// (RULE4) Parameter changes need a preceding enable; inquiries need none.
// (RULE5) A parameter command with empty value returns the current value.
// (RULE6) Accepted changes act at once from working storage.
// (RULE7) Store command after write enable copies working settings to nonvolatile.
// (RULE8) The four direct-store parameters go straight to nonvolatile after write enable.
// (RULE9) Window width is percent of full scale; set-point option captures a set point.
// (RULE10) Positive slope trim moves slope by a fixed full-scale step per count.
// (RULE11) Negative slope trim acts only on the negative side of differential units.
// (RULE12) Offset trim in fixed steps; null option zeroes output at zero pressure.
// (RULE13) Output is a 12-bit converter code; span adjusts in one-percent steps.
// (RULE14) Window width is limited to 0..99; zero means full window.
// (RULE15) Slope and offset trims are bounded symmetrically about zero.
// (RULE16) Commands for another address are ignored silently.
`timescale 1ns/1ps
`include "cfg_parser_consts.svh"
module serial_config_command_parser (
  input  wire logic              CORE_CLK_I,
  input  wire logic              RST_I,
  input  wire logic              CE_I,
  input  wire logic [7:0]        RX_DATA_I,
  input  wire logic              RX_VALID_I,
  input  wire logic              TX_READY_I,
  input  wire logic [11:0]       PRESS_I,
  input  wire logic              DIFF_UNIT_I,
  input  wire logic              POWER_UP_I,
  output logic                   RX_READY_O,
  output cfg_parser_pkg::char_t  TX_DATA_O,
  output logic                   TX_VALID_O,
  output logic [11:0]            DAC_CODE_O,
  output logic                   WRITE_EN_O,
  output logic                   NV_WRITE_O,
  output logic                   CMD_REJECT_O
);
  import cfg_parser_pkg::*;

  parse_state_t      state;
  logic [3:0]        a_hi, a_lo;
  logic              addr_cnt;
  char_t             name0, name1, val_chr0;
  logic              has_eq, val_empty, val_neg, val_alpha;
  logic [9:0]        val_num;
  logic [6:0]        w_pct, nv_w, own_addr, nv_addr;
  logic              setpt_mode, nv_setpt_mode;
  logic [11:0]       setpoint, nv_setpoint;
  trim_t             x_trim, y_trim, z_trim, nv_x, nv_y, nv_z;
  logic signed [12:0] null_adj, nv_null;
  direct_t           direct [4];
  direct_t           nv_direct [4];
  logic              en_any, en_we;
  char_t             rep [`REP_DEPTH];
  logic [3:0]        rep_len, tx_idx;

  // Byte classification
  wire logic        rx_take  = CE_I && RX_VALID_I && RX_READY_O;
  wire logic        is_digit = (RX_DATA_I >= `CHR_ZERO) && (RX_DATA_I <= `CHR_NINE);
  wire logic        is_cr    = RX_DATA_I == `CHR_CR; // RULE1
  wire logic [13:0] num_ext  = {4'h0, val_num} * 14'd10 + {10'h000, RX_DATA_I[3:0]};
  wire logic [9:0]  next_num = (num_ext > `NUM_SAT) ? 10'(`NUM_SAT) : num_ext[9:0];

  // Command decode
  wire logic [6:0]  addr_val  = {3'b000, a_hi} * 7'd10 + {3'b000, a_lo};
  wire logic        assigned  = own_addr != `NULL_ADDR;
  wire logic        mine      = assigned ? (addr_val == own_addr) : (addr_val == `NULL_ADDR); // RULE2 RULE16
  wire logic        single    = has_eq && (name1 == `NAME_NONE);
  wire logic        p_w       = single && name0 == `CHR_W;
  wire logic        p_x       = single && name0 == `CHR_X;
  wire logic        p_y       = single && name0 == `CHR_Y;
  wire logic        p_z       = single && name0 == `CHR_Z;
  wire logic        p_dir     = single && name0 >= `CHR_A && name0 <= `CHR_D;
  wire logic [1:0]  dir_idx   = 2'(name0 - `CHR_A);
  wire logic        p_ident   = has_eq && name0 == `CHR_I && name1 == `CHR_D;
  wire logic        known     = p_w || p_x || p_y || p_z || p_dir || p_ident;
  wire logic        cmd_we    = !has_eq && name0 == `CHR_W && name1 == `CHR_E;
  wire logic        cmd_alt   = !has_eq && name0 == `CHR_N && name1 == `CHR_E;
  wire logic        cmd_store = !has_eq && name0 == `CHR_S && name1 == `CHR_P;
  wire logic        go        = CE_I && state == ST_EXEC && mine;
  wire logic        change    = known && !val_empty;
  wire logic        allowed   = p_dir ? en_we : en_any; // RULE4
  wire logic        ok_change = go && change && allowed; // RULE4
  wire logic        reply_go  = go && known && val_empty; // RULE5
  wire logic        do_store  = go && cmd_store && en_we; // RULE7
  wire logic        z_cal     = val_alpha && val_chr0 == `CHR_C; // RULE12
  wire logic        w_setpt   = val_alpha && val_chr0 == `CHR_S; // RULE9

  // Value limiting; trims saturate symmetric about zero
  wire logic [6:0]  w_val     = (val_num > `W_PCT_MAX) ? 7'd99 : val_num[6:0]; // RULE14
  wire logic [6:0]  addr_new  = (val_num > `ADDR_MAX) ? 7'd99 : val_num[6:0];
  wire logic [7:0]  trim_mag  = (val_num > `TRIM_LIMIT) ? 8'd120 : val_num[7:0]; // RULE15
  wire trim_t       trim_val  = val_neg ? -$signed(trim_mag) : $signed(trim_mag); // RULE15
  wire logic [11:0] null_ref  = DIFF_UNIT_I ? `MID_CODE : 12'h000;
  wire logic signed [12:0] null_new = $signed({1'b0, null_ref}) - $signed({1'b0, PRESS_I}); // RULE12

  // Value reported on inquiry
  wire trim_t       trim_sel  = p_x ? x_trim : (p_y ? y_trim : z_trim);
  wire logic        trim_q    = p_x || p_y || p_z;
  wire logic        rep_neg   = trim_q && trim_sel[7];
  wire logic [7:0]  trim_abs  = trim_sel[7] ? 8'(-trim_sel) : 8'(trim_sel);
  wire logic [9:0]  rep_mag   = trim_q ? {2'b00, trim_abs} :
                                p_w ? {3'b000, w_pct} :
                                p_ident ? {3'b000, own_addr} : direct[dir_idx]; // RULE5
  wire logic [3:0]  dig_h     = 4'(rep_mag / 10'd100);
  wire logic [3:0]  dig_t     = 4'((rep_mag / 10'd10) % 10'd10);
  wire logic [3:0]  dig_o     = 4'(rep_mag % 10'd10);
  wire logic [3:0]  own_hi    = 4'(own_addr / 7'd10);
  wire logic [3:0]  own_lo    = 4'(own_addr % 7'd10);

  char_t      next_rep [`REP_DEPTH];
  logic [3:0] next_len;
  always_comb begin
    for (int k = 0; k < `REP_DEPTH; k++) begin
      next_rep[k] = `CHR_CR;
    end
    next_len = 4'd0;
    // Prefix shows whether the unit has been given an address
    next_rep[0] = assigned ? `CHR_HASH : `CHR_QUERY; // RULE3
    next_rep[1] = assigned ? (`CHR_ZERO + {4'h0, own_hi}) : `CHR_ZERO; // RULE3
    next_rep[2] = assigned ? (`CHR_ZERO + {4'h0, own_lo}) : `CHR_ONE; // RULE3
    next_rep[3] = name0;
    next_len = 4'd4;
    if (name1 != `NAME_NONE) begin
      next_rep[next_len] = name1;
      next_len = next_len + 4'd1;
    end
    next_rep[next_len] = `CHR_EQ;
    next_len = next_len + 4'd1;
    if (rep_neg) begin
      next_rep[next_len] = `CHR_MINUS;
      next_len = next_len + 4'd1;
    end
    if (dig_h != 4'h0) begin
      next_rep[next_len] = `CHR_ZERO + {4'h0, dig_h};
      next_len = next_len + 4'd1;
    end
    if (dig_h != 4'h0 || dig_t != 4'h0) begin
      next_rep[next_len] = `CHR_ZERO + {4'h0, dig_t};
      next_len = next_len + 4'd1;
    end
    next_rep[next_len] = `CHR_ZERO + {4'h0, dig_o};
    next_len = next_len + 4'd2;
  end

  // Parser and reply sequencer
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state <= ST_IDLE;
      {a_hi, a_lo, addr_cnt} <= 9'h000;
      {name0, name1, val_chr0} <= 24'h000000;
      {has_eq, val_empty, val_neg, val_alpha} <= 4'h4;
      val_num <= 10'h000;
      RX_READY_O <= 1'b1;
      TX_VALID_O <= 1'b0;
      TX_DATA_O <= 8'h00;
      tx_idx <= 4'h0;
      rep_len <= 4'h0;
      for (int k = 0; k < `REP_DEPTH; k++) rep[k] <= 8'h00;
    end else if (CE_I) begin
      unique case (state)
        ST_IDLE: if (rx_take && RX_DATA_I == `CHR_STAR) begin // RULE2
          state <= ST_ADDR;
          {addr_cnt, name0, name1, has_eq, val_neg, val_alpha} <= 20'h00000;
          val_empty <= 1'b1;
          val_num <= 10'h000;
        end
        ST_ADDR: if (rx_take) begin
          if (!is_digit) state <= is_cr ? ST_IDLE : ST_SKIP;
          else begin
            a_hi <= addr_cnt ? a_hi : RX_DATA_I[3:0];
            a_lo <= RX_DATA_I[3:0];
            addr_cnt <= 1'b1;
            if (addr_cnt) state <= ST_NAME;
          end
        end
        ST_NAME: if (rx_take) begin
          if (is_cr) begin
            state <= ST_EXEC; // RULE1
            RX_READY_O <= 1'b0;
          end else if (RX_DATA_I == `CHR_EQ && name0 != `NAME_NONE) begin
            has_eq <= 1'b1;
            state <= ST_VALUE;
          end else if (name0 == `NAME_NONE) name0 <= RX_DATA_I;
          else if (name1 == `NAME_NONE) name1 <= RX_DATA_I;
          else state <= ST_SKIP;
        end
        ST_VALUE: if (rx_take) begin
          if (is_cr) begin
            state <= ST_EXEC; // RULE1
            RX_READY_O <= 1'b0;
          end else begin
            val_empty <= 1'b0;
            if (RX_DATA_I == `CHR_MINUS && val_empty) val_neg <= 1'b1;
            else if (is_digit) val_num <= next_num;
            else begin
              val_alpha <= 1'b1;
              if (!val_alpha) val_chr0 <= RX_DATA_I;
            end
          end
        end
        ST_SKIP: if (rx_take && is_cr) state <= ST_IDLE;
        ST_EXEC: begin
          // Foreign or non-inquiry commands get no answer
          if (reply_go) begin // RULE5 RULE16
            state <= ST_REPLY;
            rep <= next_rep;
            rep_len <= next_len;
            tx_idx <= 4'h0;
          end else begin
            state <= ST_IDLE;
            RX_READY_O <= 1'b1;
          end
        end
        ST_REPLY: if (!TX_VALID_O) begin
          TX_VALID_O <= 1'b1;
          TX_DATA_O <= rep[tx_idx];
        end else if (TX_READY_I) begin
          TX_VALID_O <= 1'b0;
          tx_idx <= tx_idx + 4'h1;
          if (tx_idx == rep_len - 4'h1) begin
            state <= ST_IDLE;
            RX_READY_O <= 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Working configuration, applied to the output path at once
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      {w_pct, setpt_mode, setpoint, own_addr} <= 27'h0000000;
      {x_trim, y_trim, z_trim} <= {3{`TRIM_RESET}};
      null_adj <= 13'sh0000;
    end else if (CE_I) begin
      if (POWER_UP_I) begin
        // Saved copy becomes the running state
        {w_pct, setpt_mode, setpoint, own_addr} <= {nv_w, nv_setpt_mode, nv_setpoint, nv_addr}; // RULE7
        {x_trim, y_trim, z_trim, null_adj} <= {nv_x, nv_y, nv_z, nv_null};
      end else if (ok_change) begin // RULE6
        if (p_w && w_setpt) begin
          setpt_mode <= 1'b1; // RULE9
          setpoint <= PRESS_I;
        end else if (p_w) begin
          w_pct <= w_val; // RULE9 RULE14
          setpt_mode <= 1'b0;
        end
        if (p_x) x_trim <= trim_val; // RULE10 RULE15
        if (p_y) y_trim <= trim_val; // RULE11
        if (p_z && z_cal) null_adj <= null_new; // RULE12
        else if (p_z) z_trim <= trim_val; // RULE12 RULE15
        if (p_ident) own_addr <= addr_new;
      end
    end
  end

  // Nonvolatile copy and enables
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      {nv_w, nv_setpt_mode, nv_setpoint, nv_addr} <= 27'h0000000;
      {nv_x, nv_y, nv_z} <= {3{`TRIM_RESET}};
      nv_null <= 13'sh0000;
      {en_any, en_we, NV_WRITE_O, CMD_REJECT_O} <= 4'h0;
    end else if (CE_I) begin
      NV_WRITE_O <= do_store || (ok_change && p_dir); // RULE7 RULE8
      CMD_REJECT_O <= go && ((change && !allowed) || (cmd_store && !en_we));
      if (do_store) begin // RULE7
        {nv_w, nv_setpt_mode, nv_setpoint, nv_addr} <= {w_pct, setpt_mode, setpoint, own_addr};
        {nv_x, nv_y, nv_z, nv_null} <= {x_trim, y_trim, z_trim, null_adj};
      end
      // An enable covers only the next changing or store command
      if (go && (cmd_we || cmd_alt)) begin // RULE4
        en_any <= 1'b1;
        en_we <= cmd_we;
      end else if (go && (change || cmd_store)) begin
        en_any <= 1'b0;
        en_we <= 1'b0;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_direct
      wire logic hit = ok_change && p_dir && dir_idx == 2'(g);
      always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
          direct[g] <= 10'h000;
          nv_direct[g] <= 10'h000;
        end else if (CE_I) begin
          if (hit) begin
            direct[g] <= val_num; // RULE8
            nv_direct[g] <= val_num; // RULE8
          end else if (POWER_UP_I) direct[g] <= nv_direct[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) WRITE_EN_O <= 1'b0;
    else if (CE_I) WRITE_EN_O <= (go && (cmd_we || cmd_alt)) || (en_any && !(go && (change || cmd_store)));
  end

  output_scaler u_scaler (
    .clk_i        (CORE_CLK_I),
    .rst_i        (RST_I),
    .ce_i         (CE_I),
    .press_i      (PRESS_I),
    .diff_i       (DIFF_UNIT_I),
    .w_pct_i      (w_pct),
    .setpt_mode_i (setpt_mode),
    .setpoint_i   (setpoint),
    .x_trim_i     (x_trim),
    .y_trim_i     (y_trim),
    .z_trim_i     (z_trim),
    .null_adj_i   (null_adj),
    .dac_code_o   (DAC_CODE_O)
  );

  reply_prefix_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE3
    (state == ST_REPLY && TX_VALID_O && tx_idx == 4'h0) |-> TX_DATA_O == (assigned ? `CHR_HASH : `CHR_QUERY))
    else $error("reply prefix wrong");
  change_gated_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE4
    (go && change && !en_any && !POWER_UP_I) |=> $stable(w_pct) && $stable(x_trim) && $stable(z_trim))
    else $error("change taken without enable");
  inquiry_reply_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE5
    reply_go |=> state == ST_REPLY ##[1:40] state == ST_IDLE)
    else $error("inquiry not answered");
  store_copy_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE7
    do_store |=> nv_w == $past(w_pct) && nv_x == $past(x_trim) && NV_WRITE_O)
    else $error("store did not copy");
  direct_nv_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE8
    (ok_change && p_dir) |=> NV_WRITE_O && nv_direct[$past(dir_idx)] == $past(val_num))
    else $error("direct parameter not saved");
  window_limit_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE14
    w_pct <= 7'd99)
    else $error("window width over limit");
  trim_bound_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE15
    (x_trim <= 8'sd120 && x_trim >= -8'sd120 && z_trim <= 8'sd120 && z_trim >= -8'sd120))
    else $error("trim out of range");
  foreign_quiet_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE16
    (CE_I && state == ST_EXEC && !mine) |=> state == ST_IDLE && !TX_VALID_O)
    else $error("foreign command answered");
endmodule

/* verification/host_model.sv */
// Purpose: Host side model that sends addressed commands and collects replies
// Assumes: Byte strobes are in step with the parser clock
// Notes:   Slow mode drops tx_ready on every other cycle to stress the reply handshake
`timescale 1ns/1ps
module host_model (
  input  wire logic                  clk_i,
  input  wire logic                  rx_ready_i,
  input  wire cfg_parser_pkg::char_t tx_data_i,
  input  wire logic                  tx_valid_i,
  input  wire logic                  rej_i,
  input  wire logic                  nv_i,
  output logic [7:0]                 rx_data_o,
  output logic                       rx_valid_o,
  output logic                       tx_ready_o,
  output logic                       hang_o
);
  import cfg_parser_pkg::*;
  string reply   = "";
  logic  slow    = 1'b0;
  int    rej_cnt = 0;
  int    nv_cnt  = 0;
  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    tx_ready_o = 1'b1;
    hang_o = 1'b0;
  end
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) reply = {reply, string'(tx_data_i)};
    if (rej_i) rej_cnt++;
    if (nv_i) nv_cnt++;
    #1 tx_ready_o = slow ? ~tx_ready_o : 1'b1;
  end
  // Held until taken; entered one delay after an edge
  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    rx_data_o = b;
    rx_valid_o = 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (!rx_ready_i && n < 50);
    if (!rx_ready_i) hang_o = 1'b1;
    #1;
  endtask
  task automatic send_cmd(input string s);
    int n;
    reply = "";
    @(posedge clk_i);
    #1;
    for (int i = 0; i < s.len(); i++) put(s[i]);
    put(8'h0d);
    rx_valid_o = 1'b0;
    // Released line shows the inverse, never a stale byte
    rx_data_o = ~rx_data_o;
    n = 0;
    while (!rx_ready_i && n < 300) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (!rx_ready_i) hang_o = 1'b1;
  endtask
endmodule

/* verification/tb_serial_config_command_parser.sv */
// Purpose: Self-checking bench for the command parser
// Assumes: Non-differential unit, pressure code 0x320, except where t_limits sets diff or pressure 0
// Notes:   Pressure 800 keeps the X slope trim product exact
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_serial_config_command_parser;
  import cfg_parser_pkg::*;
  logic        clk   = 1'b0;
  logic        rst   = 1'b1;
  logic        ce    = 1'b1;
  logic [11:0] press = 12'h320;
  logic        diff  = 1'b0;
  logic        pwr   = 1'b0;
  logic [7:0]  rx_data;
  logic        rx_valid, tx_ready, hang, rx_ready, tx_valid, write_en, nv_write, cmd_reject;
  char_t       tx_data;
  logic [11:0] dac;
  int          error_cnt = 0;
  int          checks    = 0;
  always #50 clk = ~clk;
  serial_config_command_parser u_serial_config_command_parser (.CORE_CLK_I(clk), .RST_I(rst), .CE_I(ce),
    .RX_DATA_I(rx_data), .RX_VALID_I(rx_valid), .TX_READY_I(tx_ready), .PRESS_I(press), .DIFF_UNIT_I(diff),
    .POWER_UP_I(pwr), .RX_READY_O(rx_ready), .TX_DATA_O(tx_data), .TX_VALID_O(tx_valid), .DAC_CODE_O(dac),
    .WRITE_EN_O(write_en), .NV_WRITE_O(nv_write), .CMD_REJECT_O(cmd_reject));
  host_model u_host_model (.clk_i(clk), .rx_ready_i(rx_ready), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
    .rej_i(cmd_reject), .nv_i(nv_write), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .tx_ready_o(tx_ready),
    .hang_o(hang));
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // A stuck handshake ends the run at once
  always @(posedge hang) begin
    error_cnt++;
    wrap_up();
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmd(input string s);
    u_host_model.send_cmd(s);
  endtask
  task automatic set(input string s);
    cmd("*00WE");
    cmd(s);
  endtask
  task automatic ask(input string s, input string exp);
    cmd(s);
    `CHK(u_host_model.reply == exp, 1'b1)
  endtask
  task automatic power_up;
    pwr = 1'b1;
    wait_n(1);
    pwr = 1'b0;
  endtask
  task automatic t_reset;
    wait_n(3);
    `CHK(dac, 12'h320)
    `CHK(write_en, 1'b0)
    `CHK(rx_ready, 1'b1)
    `CHK(tx_valid, 1'b0)
    $display("t_reset done");
  endtask
  task automatic t_enable;
    int r0;
    r0 = u_host_model.rej_cnt;
    cmd("*00X=17");
    wait_n(3);
    `CHK(u_host_model.rej_cnt, r0 + 1)
    ask("*00X=", "?01X=0\r");
    cmd("*00WE");
    ask("*00X=", "?01X=0\r");
    `CHK(write_en, 1'b1)
    cmd("*00X=25");
    `CHK(write_en, 1'b0)
    wait_n(4);
    `CHK(dac, 12'h321)
    ask("*00X=", "?01X=25\r");
    cmd("*00NE");
    cmd("*00X=0");
    ask("*00X=", "?01X=0\r");
    $display("t_enable done");
  endtask
  task automatic t_limits;
    set("*00X=-500");
    ask("*00X=", "?01X=-120\r");
    set("*00X=0");
    set("*00W=150");
    ask("*00W=", "?01W=99\r");
    set("*00W=50");
    wait_n(4);
    `CHK(dac, 12'h640)
    set("*00W=10");
    wait_n(4);
    `CHK(dac, 12'hfff)
    set("*00W=S");
    wait_n(4);
    `CHK(dac, 12'h000)
    set("*00W=0");
    set("*00Z=20");
    wait_n(4);
    `CHK(dac, 12'h324)
    set("*00Z=0");
    set("*00Z=CAL");
    wait_n(4);
    `CHK(dac, 12'h000)
    // Null taken at zero input clears the correction again
    press = 12'h000;
    set("*00Z=CAL");
    press = 12'h320;
    set("*00Y=100");
    wait_n(4);
    `CHK(dac, 12'h320)
    diff = 1'b1;
    wait_n(4);
    `CHK(dac, 12'h31a)
    diff = 1'b0;
    wait_n(4);
    $display("t_limits done");
  endtask
  task automatic t_store;
    int n0;
    n0 = u_host_model.nv_cnt;
    cmd("*00NE");
    cmd("*00SP");
    wait_n(3);
    `CHK(u_host_model.nv_cnt, n0)
    set("*00SP");
    wait_n(3);
    `CHK(u_host_model.nv_cnt, n0 + 1)
    set("*00X=25");
    power_up();
    ask("*00X=", "?01X=0\r");
    set("*00A=7");
    wait_n(3);
    `CHK(u_host_model.nv_cnt, n0 + 2)
    cmd("*00NE");
    cmd("*00B=5");
    ask("*00B=", "?01B=0\r");
    power_up();
    ask("*00A=", "?01A=7\r");
    `CHK(u_host_model.nv_cnt, n0 + 2)
    $display("t_store done");
  endtask
  task automatic t_addr;
    set("*00ID=12");
    ask("*00W=", "");
    u_host_model.slow = 1'b1;
    ask("*12W=", "#12W=0\r");
    u_host_model.slow = 1'b0;
    $display("t_addr done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    t_reset();
    t_enable();
    t_limits();
    t_store();
    t_addr();
    wrap_up();
  end
endmodule
